// File: include/adc_link_pkg.sv
// shared link constants
package adc_link_pkg;
    localparam int         ADDR_W     = 3;
    localparam int         DATA_W     = 16;
    localparam int         FRAME_BITS = 19;
    localparam logic [4:0] XFER_EDGE  = 5'h13;
    // register addresses on the link
    localparam logic [2:0] A_MAIN   = 3'h0;
    localparam logic [2:0] A_OFFSET = 3'h2;
    localparam logic [2:0] A_GAIN   = 3'h3;
    localparam logic [2:0] A_TEST   = 3'h5;
    localparam logic [2:0] A_DELAY  = 3'h7;
    // main, test and delay register bit positions
    localparam int B_STBY_I = 0;
    localparam int B_STBY_Q = 1;
    localparam int B_BINARY = 2;
    localparam int B_DEMUX  = 3;
    localparam int B_IN_LO  = 4;
    localparam int B_IN_HI  = 5;
    localparam int B_CK_LO  = 6;
    localparam int B_CK_HI  = 7;
    localparam int B_DECIM  = 8;
    localparam int B_RSVD   = 9;
    localparam int B_CAL_LO = 10;
    localparam int B_CAL_HI = 11;
    localparam int B_WAIT_B = 12;
    localparam int B_WAIT_A = 13;
    localparam int B_RATE   = 14;
    localparam int B_TRANSP = 4;
    localparam int DLY_I_LSB = 0;
    localparam int DLY_Q_LSB = 3;
    // values after reset
    localparam logic [15:0] MAIN_RST   = 16'h00b4;
    localparam logic [15:0] OFFSET_RST = 16'h8080;
    localparam logic [15:0] GAIN_RST   = 16'h0080;
    localparam logic [15:0] TEST_RST   = 16'h0000;
    localparam logic [15:0] DELAY_RST  = 16'h0424;
    // delay code scaling in picoseconds
    localparam int DLY_STEP_PS   = 140;
    localparam int DLY_ZERO_CODE = 4;
    // calibration lengths in primary clock periods
    localparam int CAL_500 = 10112;
    localparam int CAL_250 = 6016;
    localparam int CAL_125 = 3968;
    localparam int CAL_LOW = 2944;
    // host rate thresholds, sclk half period
    localparam int RATE_HI    = 500;
    localparam int RATE_MID   = 250;
    localparam int RATE_LO    = 125;
    localparam int SCLK_HALF  = 4;
    localparam logic [2:0] R_ADDR = 3'h0;
    localparam logic [2:0] R_DATA = 3'h1;
    localparam logic [2:0] R_GO   = 3'h2;
    localparam logic [2:0] R_STAT = 3'h3;
    localparam logic [2:0] R_IRQ  = 3'h4;
    localparam logic [2:0] R_MASK = 3'h5;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_CAL    = 1;
    localparam int IRQ_REFUSE = 2;
    typedef enum logic [1:0] {CK_OWN, CK_PRIMARY, CK_INVERTED} clk_route_t;
endpackage

// File: include/adc_serial_if.sv
// three-wire write link plus calibration busy line
`timescale 1ns/1ps
interface adc_serial_if;
    logic sclk;
    logic sldn;
    logic sdata;
    logic cal_busy;
    modport device (input sclk, input sldn, input sdata, output cal_busy);
    modport host (output sclk, output sldn, output sdata, input cal_busy);
endinterface

// File: logic/adc_ctrl_decode.sv
// converter end: link receiver and decode
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// Behaviour
// - bits 1:0 select full, I, Q standby
// - bits 5:4 route analog inputs
// - bits 7:6 route sampling clocks
// - bits 11:10 start, keep or disable calibration
// - held calibration uses last results or defaults
// - manual mode uses offset, gain registers
// - host sets wait bits by sample rate
// - bit 14 sets ready rate in 1:2
// - host always writes bit 9 zero
// - no shared clocks while only channel I in standby
// - prefer Q standby over I standby
// - gray overrange zeroes bits 6:0
// - one overrange flag in 1:2
// - delay field shifts ready clock -560..+420 ps
// - test bit 4 bypasses track/hold
// - 3 address then 16 data bits, MSB first
// - busy output high throughout calibration
module adc_ctrl_decode
    import adc_link_pkg::*;
#(
    parameter int CAL_CYC_500 = CAL_500,
    parameter int CAL_CYC_250 = CAL_250,
    parameter int CAL_CYC_125 = CAL_125,
    parameter int CAL_CYC_LOW = CAL_LOW
) (
    input  wire logic         clock,
    input  wire logic         reset,
    adc_serial_if.device      link,
    input  wire logic [15:0]  cal_offset_result,
    input  wire logic [15:0]  cal_gain_result,
    input  wire logic         raw_oor_i,
    input  wire logic         raw_oor_q,
    output logic              standby_i,
    output logic              standby_q,
    output logic              conv_i_takes_q,
    output logic              conv_q_takes_i,
    output clk_route_t        clk_route,
    output logic              binary_out,
    output logic              demux_1to2,
    output logic              decimation,
    output logic              ready_rate_div4,
    output logic              transparent_mode,
    output logic signed [10:0] ready_delay_i_ps,
    output logic signed [10:0] ready_delay_q_ps,
    output logic [15:0]       offset_comp,
    output logic [15:0]       gain_comp,
    output logic              out_of_range_flag_i,
    output logic              out_of_range_flag_q
);

    ////////////////////////////////////////////////////////////////////
    // delay code to signed picoseconds
    function automatic logic signed [10:0] delay_ps(input logic [2:0] code);
        int v;
        v = (int'(code) - DLY_ZERO_CODE) * DLY_STEP_PS;
        return v[10:0];
    endfunction

    // calibration length from wait bits
    function automatic logic [13:0] cal_len(input logic [1:0] ab);
        int v;
        case (ab)
            2'b11:   v = CAL_CYC_500;
            2'b10:   v = CAL_CYC_250;
            2'b01:   v = CAL_CYC_125;
            default: v = CAL_CYC_LOW;
        endcase
        return v[13:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // link inputs come from another domain
    logic [2:0]  sclk_sync_ff;
    logic [1:0]  sldn_sync_ff;
    logic [1:0]  sdata_sync_ff;
    logic        sclk_rise;

    // two flops each; third finds sclk edges
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sclk_sync_ff  <= 3'b000;
            sldn_sync_ff  <= 2'b11;
            sdata_sync_ff <= 2'b00;
        end else begin
            sclk_sync_ff  <= {sclk_sync_ff[1:0], link.sclk};
            sldn_sync_ff  <= {sldn_sync_ff[0], link.sldn};
            sdata_sync_ff <= {sdata_sync_ff[0], link.sdata};
        end
    end

    assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];

    ////////////////////////////////////////////////////////////////////
    // frame receiver
    logic        armed_ff;
    logic [4:0]  bit_cnt_ff;
    logic [18:0] shift_ff;
    logic        wr_stb_ff;
    logic [2:0]  wr_addr_ff;
    logic [15:0] wr_data_ff;

    // a frame needs one idle edge first; a high sldn aborts it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            armed_ff   <= 1'b0;
            bit_cnt_ff <= 5'h00;
            shift_ff   <= '0;
            wr_stb_ff  <= 1'b0;
            wr_addr_ff <= 3'h0;
            wr_data_ff <= 16'h0000;
        end else begin
            wr_stb_ff <= 1'b0;
            if (sclk_rise) begin
                if (sldn_sync_ff[1]) begin
                    armed_ff   <= 1'b1;
                    bit_cnt_ff <= 5'h00;
                end else if (armed_ff) begin
                    if (bit_cnt_ff == XFER_EDGE) begin
                        // 20th edge: parallel transfer
                        wr_stb_ff  <= 1'b1;
                        wr_addr_ff <= shift_ff[18:16];
                        wr_data_ff <= shift_ff[15:0];
                        armed_ff   <= 1'b0; // extra edges ignored
                    end else begin
                        shift_ff   <= {shift_ff[17:0], sdata_sync_ff[1]};
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register bank; writes are inhibited while calibrating
    logic [15:0] main_ff;
    logic [15:0] offset_ff;
    logic [15:0] gain_ff;
    logic [15:0] test_ff;
    logic [15:0] delay_ff;
    logic        cal_busy_ff;
    logic        wr_ok;

    assign wr_ok = wr_stb_ff & ~cal_busy_ff;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            main_ff   <= MAIN_RST;
            offset_ff <= OFFSET_RST;
            gain_ff   <= GAIN_RST;
            test_ff   <= TEST_RST;
            delay_ff  <= DELAY_RST;
        end else if (wr_ok) begin
            // other addresses dropped
            if (wr_addr_ff == A_MAIN) begin
                main_ff <= wr_data_ff;
            end else if (wr_addr_ff == A_OFFSET) begin
                offset_ff <= wr_data_ff;
            end else if (wr_addr_ff == A_GAIN) begin
                gain_ff <= wr_data_ff;
            end else if (wr_addr_ff == A_TEST) begin
                test_ff <= wr_data_ff;
            end else if (wr_addr_ff == A_DELAY) begin
                delay_ff <= wr_data_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // calibration timer
    logic        cal_start;
    logic [13:0] cal_cnt_ff;
    logic [15:0] cal_off_ff;
    logic [15:0] cal_gain_ff;

    // both calibration bits set start a phase
    assign cal_start = wr_ok && wr_addr_ff == A_MAIN
                    && wr_data_ff[B_CAL_HI] && wr_data_ff[B_CAL_LO];

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cal_busy_ff <= 1'b0;
            cal_cnt_ff  <= 14'h0000;
        end else if (cal_start) begin
            cal_busy_ff <= 1'b1;
            cal_cnt_ff  <= cal_len(wr_data_ff[B_WAIT_A:B_WAIT_B]);
        end else if (cal_busy_ff) begin
            cal_cnt_ff <= cal_cnt_ff - 14'h0001;
            if (cal_cnt_ff == 14'h0001) begin
                cal_busy_ff <= 1'b0;
            end
        end
    end

    // reset defaults until a phase ends
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cal_off_ff  <= OFFSET_RST;
            cal_gain_ff <= GAIN_RST;
        end else if (cal_busy_ff && cal_cnt_ff == 14'h0001) begin
            cal_off_ff  <= cal_offset_result;
            cal_gain_ff <= cal_gain_result;
        end
    end

    assign link.cal_busy = cal_busy_ff;

    ////////////////////////////////////////////////////////////////////
    // decoded controls, registered
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            standby_i        <= 1'b0;
            standby_q        <= 1'b0;
            conv_i_takes_q   <= 1'b0;
            conv_q_takes_i   <= 1'b0;
            clk_route        <= CK_OWN;
            binary_out       <= 1'b0;
            demux_1to2       <= 1'b0;
            decimation       <= 1'b0;
            ready_rate_div4  <= 1'b0;
            transparent_mode <= 1'b0;
        end else begin
            standby_i      <= main_ff[B_STBY_I];
            standby_q      <= main_ff[B_STBY_Q];
            conv_i_takes_q <= ~main_ff[B_IN_HI];
            conv_q_takes_i <= main_ff[B_IN_HI] & ~main_ff[B_IN_LO];
            if (!main_ff[B_CK_HI]) begin
                clk_route <= CK_INVERTED;
            end else if (!main_ff[B_CK_LO]) begin
                clk_route <= CK_PRIMARY;
            end else begin
                clk_route <= CK_OWN;
            end
            // calibration forces binary, 1:1 and decimation on
            binary_out      <= main_ff[B_BINARY] | cal_busy_ff;
            demux_1to2      <= main_ff[B_DEMUX] & ~cal_busy_ff;
            decimation      <= main_ff[B_DECIM] | cal_busy_ff;
            ready_rate_div4 <= main_ff[B_RATE] & main_ff[B_DEMUX]
                             & ~cal_busy_ff;
            transparent_mode <= test_ff[B_TRANSP];
        end
    end

    // ready clock shift and compensation source
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ready_delay_i_ps <= '0;
            ready_delay_q_ps <= '0;
            offset_comp      <= OFFSET_RST;
            gain_comp        <= GAIN_RST;
        end else begin
            ready_delay_i_ps <= delay_ps(delay_ff[DLY_I_LSB +: 3]);
            ready_delay_q_ps <= delay_ps(delay_ff[DLY_Q_LSB +: 3]);
            if (!main_ff[B_CAL_HI] && !main_ff[B_CAL_LO]) begin
                offset_comp <= offset_ff;
                gain_comp   <= gain_ff;
            end else begin
                offset_comp <= cal_off_ff;
                gain_comp   <= cal_gain_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // overrange: one flag for both ports in 1:2
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            out_of_range_flag_i <= 1'b0;
            out_of_range_flag_q <= 1'b0;
        end else if (demux_1to2) begin
            out_of_range_flag_i <= raw_oor_i | raw_oor_q;
            out_of_range_flag_q <= raw_oor_i | raw_oor_q;
        end else begin
            out_of_range_flag_i <= raw_oor_i;
            out_of_range_flag_q <= raw_oor_q;
        end
    end

endmodule

// File: logic/adc_link_host.sv
// host end: register port and link shifter
`timescale 1ns/1ps
module adc_link_host
    import adc_link_pkg::*;
#(
    parameter int SAMPLE_MSPS = RATE_HI,
    parameter int HALF_CYC    = SCLK_HALF
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [15:0]      reg_rdata,
    output logic             irq,
    input  wire logic [7:0]  sample_in,
    input  wire logic        sample_oor,
    output logic [7:0]       sample_out,
    adc_serial_if.host       link
);

    // wait bits a, b fixed by the sample rate
    localparam logic [1:0] WAIT_AB = (SAMPLE_MSPS >= RATE_HI) ? 2'b11
                                   : (SAMPLE_MSPS > RATE_MID) ? 2'b10
                                   : (SAMPLE_MSPS > RATE_LO)  ? 2'b01
                                   : 2'b00;

    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TAIL} hstate_t;

    logic [2:0]  addr_ff;
    logic [15:0] data_ff;
    logic [2:0]  mask_ff;
    logic [2:0]  irq_ff;
    logic [1:0]  busy_sync_ff;
    logic        busy_old_ff;
    logic        pend_ff;
    logic        gray_ff;
    hstate_t     state_ff;
    logic [7:0]  div_ff;
    logic        sclk_ff;
    logic        fall;
    logic [18:0] shift_ff;
    logic [4:0]  cnt_ff;
    logic        sldn_ff;
    logic        sdata_ff;
    logic        done_ev;
    logic        go;
    logic        refuse;
    logic [15:0] word;

    ////////////////////////////////////////////////////////////////////
    // free running serial clock from a divider
    assign fall = sclk_ff && div_ff == 8'(HALF_CYC - 1);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            div_ff  <= 8'h00;
            sclk_ff <= 1'b0;
        end else if (div_ff == 8'(HALF_CYC - 1)) begin
            div_ff  <= 8'h00;
            sclk_ff <= ~sclk_ff;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // busy from the other domain
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busy_sync_ff <= 2'b00;
            busy_old_ff  <= 1'b0;
        end else begin
            busy_sync_ff <= {busy_sync_ff[0], link.cal_busy};
            busy_old_ff  <= busy_sync_ff[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outgoing main word: bit 9 zero, wait bits by rate
    always_comb begin
        word = data_ff;
        if (addr_ff == A_MAIN) begin
            word[B_RSVD] = 1'b0;
            word[B_WAIT_A:B_WAIT_B] = WAIT_AB;
        end
    end

    // go; I standby clocking refused
    assign go = reg_write && reg_addr == R_GO && reg_wdata[0];
    assign refuse = go && (pend_ff || state_ff != H_IDLE
        || busy_sync_ff[1]
        || (addr_ff == A_MAIN && word[B_STBY_I] && !word[B_STBY_Q]
            && !(word[B_CK_HI] && word[B_CK_LO])));

    ////////////////////////////////////////////////////////////////////
    // shifter: change on sclk fall, sampled on rise
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= H_IDLE;
            pend_ff  <= 1'b0;
            shift_ff <= '0;
            cnt_ff   <= 5'h00;
            sldn_ff  <= 1'b1;
            sdata_ff <= 1'b0;
            done_ev  <= 1'b0;
            gray_ff  <= ~MAIN_RST[B_BINARY];
        end else begin
            done_ev <= 1'b0;
            if (go && !refuse) begin
                pend_ff  <= 1'b1;
                shift_ff <= {addr_ff, word};
                if (addr_ff == A_MAIN) begin
                    gray_ff <= ~word[B_BINARY];
                end
            end
            if (fall) begin
                case (state_ff)
                    H_IDLE: begin
                        if (pend_ff) begin
                            pend_ff  <= 1'b0;
                            sldn_ff  <= 1'b0;
                            sdata_ff <= shift_ff[18];
                            shift_ff <= {shift_ff[17:0], 1'b0};
                            cnt_ff   <= 5'h00;
                            state_ff <= H_SHIFT;
                        end
                    end
                    H_SHIFT: begin
                        if (cnt_ff == XFER_EDGE) begin
                            sldn_ff  <= 1'b1;
                            state_ff <= H_TAIL;
                        end else begin
                            cnt_ff   <= cnt_ff + 5'h01;
                            sdata_ff <= shift_ff[18];
                            shift_ff <= {shift_ff[17:0], 1'b0};
                        end
                    end
                    default: begin
                        // one idle rising edge closes the frame
                        done_ev  <= 1'b1;
                        state_ff <= H_IDLE;
                    end
                endcase
            end
        end
    end

    assign link.sclk  = sclk_ff;
    assign link.sldn  = sldn_ff;
    assign link.sdata = sdata_ff;

    ////////////////////////////////////////////////////////////////////
    // software registers; set wins over a write-one clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            addr_ff <= 3'h0;
            data_ff <= 16'h0000;
            mask_ff <= 3'h0;
            irq_ff  <= 3'h0;
        end else begin
            if (reg_write && reg_addr == R_ADDR) begin
                addr_ff <= reg_wdata[2:0];
            end else if (reg_write && reg_addr == R_DATA) begin
                data_ff <= reg_wdata;
            end else if (reg_write && reg_addr == R_MASK) begin
                mask_ff <= reg_wdata[2:0];
            end
            irq_ff <= (irq_ff & ~((reg_write && reg_addr == R_IRQ)
                                  ? reg_wdata[2:0] : 3'h0))
                    | {refuse, busy_old_ff & ~busy_sync_ff[1], done_ev};
        end
    end

    assign irq = |(irq_ff & mask_ff);

    // read data one cycle after the strobe
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_read) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == R_ADDR) begin
            reg_rdata <= {13'h0000, addr_ff};
        end else if (reg_addr == R_DATA) begin
            reg_rdata <= data_ff;
        end else if (reg_addr == R_STAT) begin
            reg_rdata <= {14'h0000, busy_sync_ff[1],
                          pend_ff | (state_ff != H_IDLE)};
        end else if (reg_addr == R_IRQ) begin
            reg_rdata <= {13'h0000, irq_ff};
        end else if (reg_addr == R_MASK) begin
            reg_rdata <= {13'h0000, mask_ff};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // gray overrange fix
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sample_out <= 8'h00;
        end else if (gray_ff && sample_oor) begin
            sample_out <= {sample_in[7], 7'h00};
        end else begin
            sample_out <= sample_in;
        end
    end

endmodule

// File: testbench/adc_link_sva.sv
// link checker
`timescale 1ns/1ps
module adc_link_sva #(
    parameter int CAL_CYC_500 = 40
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic sclk,
    input wire logic sldn,
    input wire logic sdata,
    input wire logic cal_busy
);
    logic        sclk_ff;
    logic [4:0]  cnt_ff;
    logic [19:0] bits_ff;
    logic [5:0]  blen_ff;
    logic        rise;
    assign rise = sclk & ~sclk_ff;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // rising sclk count, last frame bits
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sclk_ff <= 1'b0;
            cnt_ff  <= 5'h0;
            bits_ff <= 20'h0_0000;
        end else begin
            sclk_ff <= sclk;
            if (rise) begin
                cnt_ff  <= sldn ? 5'h0 : cnt_ff + 5'h1;
                bits_ff <= sldn ? bits_ff : {bits_ff[18:0], sdata};
            end
        end
    end
    // busy length in clocks
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            blen_ff <= 6'h0;
        end else begin
            blen_ff <= cal_busy ? blen_ff + 6'h1 : 6'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_sldn_steady: assert property ($changed(sldn) |-> !sclk)
        else $error("sldn moved while sclk high");
    a_sdata_steady: assert property (sclk && $past(sclk) |-> $stable(sdata))
        else $error("sdata moved while sclk high");
    a_frame_len: assert property ($rose(sldn) |-> cnt_ff == 5'h14)
        else $error("frame not 20 edges");
    a_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("sclk high time wrong");
    a_sclk_low: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("sclk low too short");
    a_word_fix: assert property ($rose(sldn) && bits_ff[19:17] == 3'h0
        |-> bits_ff[10] == 1'b0 && bits_ff[14:13] == 2'h3)
        else $error("bad bit9 or wait bits");
    a_busy_cause: assert property ($rose(cal_busy)
        |-> bits_ff[19:17] == 3'h0 && bits_ff[12:11] == 2'h3)
        else $error("busy without start");
    a_busy_len: assert property ($fell(cal_busy)
        |-> blen_ff == 6'(CAL_CYC_500))
        else $error("busy length wrong");
    a_busy_quiet: assert property ($fell(sldn) |-> !cal_busy)
        else $error("frame during calibration");
endmodule

// File: testbench/dual_adc_main_control_decode_test.sv
// bench: host end drives converter end
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
end
module dual_adc_main_control_decode_test import adc_link_pkg::*; ();
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [7:0]  s_in = 8'hff;
    logic        s_oor = 1'b1;
    logic        oor_i = 1'b0;
    logic        oor_q = 1'b1;
    logic [15:0] cal_ofs = 16'h1234;
    logic [15:0] reg_rdata, ofs, gn, rd_v;
    logic [7:0]  s_out;
    logic        irq, stby_i, stby_q, i_q, q_i, bin, dmx, dec, div4;
    logic        tp, fl_i, fl_q;
    clk_route_t  route;
    logic [21:0] dly;
    logic [9:0]  got;
    logic [15:0] words [5] = '{16'h04c1, 16'h07b2, 16'h446c,
                               16'h0408, 16'h0403};
    int          mismatches = 0;
    int          cmp_count = 0;
    adc_serial_if link ();
    assign got = {stby_i, stby_q, i_q, q_i, route, bin, dmx, dec, div4};
    adc_link_host adc_link_host_i (.clock(clock), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
        .sample_in(s_in), .sample_oor(s_oor), .sample_out(s_out), .link(link));
    adc_ctrl_decode #(.CAL_CYC_500(40), .CAL_CYC_250(16), .CAL_CYC_125(12),
        .CAL_CYC_LOW(8)) adc_ctrl_decode_i (.clock(clock), .reset(reset),
        .link(link), .cal_offset_result(cal_ofs), .cal_gain_result(16'h0056),
        .raw_oor_i(oor_i), .raw_oor_q(oor_q), .standby_i(stby_i),
        .standby_q(stby_q), .conv_i_takes_q(i_q), .conv_q_takes_i(q_i),
        .clk_route(route), .binary_out(bin), .demux_1to2(dmx),
        .decimation(dec), .ready_rate_div4(div4), .transparent_mode(tp),
        .ready_delay_i_ps(dly[21:11]), .ready_delay_q_ps(dly[10:0]),
        .offset_comp(ofs), .gain_comp(gn), .out_of_range_flag_i(fl_i),
        .out_of_range_flag_q(fl_q));
    adc_link_sva adc_link_sva_i (.clock(clock),
        .reset(reset), .sclk(link.sclk), .sldn(link.sldn), .sdata(link.sdata),
        .cal_busy(link.cal_busy));
    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 clock = ~clock;
    // register port: one-cycle strobes
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    // link write; irq status left in rd_v
    task automatic send(input logic [2:0] a, input logic [15:0] d);
        wr(R_IRQ, 16'h0007);
        wr(R_ADDR, {13'h0000, a});
        wr(R_DATA, d);
        wr(R_GO, 16'h0001);
        rd_v = 16'h0000;
        for (int k = 0; k < 400 && rd_v[2:0] == 3'h0; k++) rd(R_IRQ);
    endtask
    function automatic logic [9:0] dec_exp(input logic [15:0] w);
        clk_route_t r;
        r = (w[7:6] == 2'h3) ? CK_OWN : (w[7] ? CK_PRIMARY : CK_INVERTED);
        return {w[0], w[1], !w[5], w[5:4] == 2'h2, r, w[2], w[3], w[8],
                w[14] & w[3]};
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #500000;
        mismatches++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        `CHK("reset ofs gain", 32'h8080_0080, {ofs, gn})
        `CHK("reset decode", dec_exp(16'h00b4), got)
        wr(R_MASK, 16'h0007);
        foreach (words[k]) begin
            send(A_MAIN, words[k]);
            `CHK("decode", dec_exp(words[k]), got)
            `CHK("oor", {words[k][3], 1'b1}, {fl_i, fl_q})
        end
        `CHK("kept cal", 16'h8080, ofs)
        `CHK("gray fix", 8'h80, s_out)
        @(posedge clock);
        s_oor <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        `CHK("gray pass", 8'hff, s_out)
        $display("decode test done");
        send(A_MAIN, 16'h0441);
        `CHK("refused", 2'h3, {rd_v[IRQ_REFUSE], irq})
        `CHK("kept word", dec_exp(16'h0403), got)
        wr(R_MASK, 16'h0000);
        #1;
        `CHK("masked irq", 1'b0, irq)
        wr(R_MASK, 16'h0007);
        send(A_OFFSET, 16'h5a5a);
        send(A_GAIN, 16'h0033);
        send(A_MAIN, 16'h0000);
        `CHK("manual comp", 32'h5a5a_0033, {ofs, gn})
        $display("refusal test done");
        send(A_MAIN, 16'h3c00);
        `CHK("cal mode", 4'hd, {link.cal_busy, bin, dmx, dec})
        send(A_MAIN, 16'h0400);
        `CHK("busy refuse", 1'b1, rd_v[IRQ_REFUSE])
        for (int k = 0; k < 100 && rd_v[IRQ_CAL] !== 1'b1; k++) rd(R_IRQ);
        `CHK("cal end", 2'h2, {rd_v[IRQ_CAL], link.cal_busy})
        `CHK("cal comp", 32'h1234_0056, {ofs, gn})
        $display("calibration test done");
        send(A_DELAY, 16'h0038);
        `CHK("delays", 22'h2e_81a4, dly)
        send(A_TEST, 16'h0010);
        `CHK("transparent", 1'b1, tp)
        rd(3'h6);
        `CHK("unmapped", 16'h0000, rd_v)
        $display("register test done");
        conclude();
    end
endmodule
